// ---- design/hasp_map.vh ----
// Offsets, field positions, codes and timing constants of the host port.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef HASP_MAP_VH
`define HASP_MAP_VH

// --------------------------------------------------------------------
// Port offsets from the jumper-set base
// --------------------------------------------------------------------
`define HASP_OFS_ATTENTION   5'h08
`define HASP_OFS_STATUS      5'h10

// --------------------------------------------------------------------
// Attention types (low two bits of the attention write)
// --------------------------------------------------------------------
`define HASP_ATT_SINGLE      2'h0
`define HASP_ATT_LIST        2'h1
`define HASP_ATT_TARGET_ACK  2'h2

// --------------------------------------------------------------------
// Status fields
// --------------------------------------------------------------------
`define HASP_ST_ENT_BIT      0
`define HASP_ST_RDY_BIT      1
`define HASP_ST_ERR_BIT      4
`define HASP_ST_RESET_VAL    8'hfd
`define HASP_BOARD_TYPE      8'h02

// --------------------------------------------------------------------
// Self-test and catastrophic codes
// --------------------------------------------------------------------
`define HASP_TC_SRAM         8'h04
`define HASP_TC_CRC          8'h0c
`define HASP_TC_ACC          8'he5
`define HASP_TC_STORE        8'he8
`define HASP_TC_SHIFT        8'he9
`define HASP_TC_CMP          8'hec
`define HASP_TC_JUMP         8'hed
`define HASP_TC_TERM_PRESENT 8'ha8
`define HASP_TC_TERM_ABSENT  8'hac
`define HASP_ERR_LIST_STATE  8'h11

// --------------------------------------------------------------------
// Test patterns, memory sizes and timing
// --------------------------------------------------------------------
`define HASP_SRAM_ONES       16'hffff
`define HASP_SRAM_ZERO       16'h0000
`define HASP_SRAM_AW         8
`define HASP_PROG_AW         8
`define HASP_CRC_INIT        16'hffff
`define HASP_CRC_POLY        16'h1021
`define HASP_SELFTEST_MS     5000
`define HASP_CLK_KHZ         10000

`endif

// ---- design/hasp_sram.v ----
// Static working memory checked by the power-up self-test.
// Assumes one clock; read data appear one edge after the address.
`include "hasp_map.vh"

module hasp_sram
(
    // Clock
    input  wire                      mclk,
    // Access
    input  wire                      we,
    input  wire [`HASP_SRAM_AW-1:0]  addr,
    input  wire [15:0]               wdata,
    output reg  [15:0]               rdata
);

    reg [15:0] mem [0:(1<<`HASP_SRAM_AW)-1];

    // Write port and registered read
    always @(posedge mclk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule // hasp_sram

// ---- design/hasp_crc.v ----
// CRC-16 engine over program memory words for the firmware check.
// Assumes one word per enabled clock, most significant bit first.
`include "hasp_map.vh"

module hasp_crc
(
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // Control and data
    input  wire        clear,
    input  wire        en,
    input  wire [15:0] data,
    output reg  [15:0] crc
);

    reg [15:0] next_crc;
    integer    i;

    // Sixteen serial steps folded into one clock
    always @*
    begin
        next_crc = crc;
        for (i = 15; i >= 0; i = i - 1)
        begin
            if (next_crc[15] ^ data[i])
                next_crc = {next_crc[14:0], 1'b0} ^ `HASP_CRC_POLY;
            else
                next_crc = {next_crc[14:0], 1'b0};
        end
    end

    // Running value
    always @(posedge mclk)
    begin
        if (!rst_n || clear)
            crc <= `HASP_CRC_INIT;
        else if (en)
            crc <= next_crc;
    end

endmodule // hasp_crc

// ---- design/hasp_top.v ----
// Host attention port and status port with the power-up self-test.
// Assumes host pins are asynchronous to mclk and held for several
// cycles per access; command engine signals share mclk.
//
// How it works
// - Attention low bits select single, list, target ack
// - Writes at offset 8H hit attention port
// - List attention without active list gives 11H
// - Run every pending block up to inbound index
// - Status is sixteen bits, two layouts
// - Load FDH right after reset
// - Test code sits in bit 0, bits 2-7
// - Ready and other fields zero during test
// - Test lasts five seconds; ready only on pass
// - Failure keeps ready clear and failing code
// - After pass switch to general layout
// - Refuse all commands after failed test
// - Ready one means commands are accepted
// - Memory test writes FFFFH then zero, fail 04H
// - Program memory CRC mismatch gives 0CH
// - Processor test failures give E5H to EDH
// - Blown fuse gives A8H or ACH
// - Keep FDH until test starts
// - Toggle entered bit per single attention only
// - Error bit selects error code or board type
`include "hasp_map.vh"

module hasp_top
#(
    parameter [31:0] SELFTEST_CYCLES = `HASP_SELFTEST_MS * `HASP_CLK_KHZ
)
(
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // Host port pins
    input  wire [4:0]  host_addr,
    input  wire        host_wr_n,
    input  wire        host_rd_n,
    input  wire [15:0] host_wdata,
    output reg  [15:0] host_rdata,
    output reg         host_rdata_oe,
    // Termination power sense pins
    input  wire        fuse_ok,
    input  wire        term_power,
    // Program memory (synchronous, data one edge after address)
    output reg  [7:0]  prog_addr,
    input  wire [15:0] prog_data,
    input  wire [15:0] stored_crc,
    // Command engine
    input  wire        list_active,
    input  wire [7:0]  list_inbound_index,
    input  wire        list_block_done,
    output reg         single_cmd_start,
    output reg         list_block_start,
    output reg  [7:0]  list_block_index,
    output reg         target_ack,
    output reg         selftest_failed
);

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [7:0] S_INIT = 8'h01;
    localparam [7:0] S_RAM  = 8'h02;
    localparam [7:0] S_CRC  = 8'h04;
    localparam [7:0] S_CPU  = 8'h08;
    localparam [7:0] S_TERM = 8'h10;
    localparam [7:0] S_WAIT = 8'h20;
    localparam [7:0] S_RUN  = 8'h40;
    localparam [7:0] S_FAIL = 8'h80;

    reg  [7:0]  state;
    reg  [7:0]  test_code;
    reg  [31:0] timer;
    reg  [1:0]  ram_phase;
    reg         ram_chk;
    reg  [7:0]  ram_addr;
    reg         crc_chk;
    reg  [2:0]  cpu_step;
    reg  [7:0]  cpu_acc;
    reg  [7:0]  cpu_store;
    reg         entered;
    reg         err;
    reg  [7:0]  err_code;
    reg         list_run;
    reg         list_busy;
    reg  [7:0]  list_out_index;

    // Host and sense synchronisers
    reg  [22:0] sync1;
    reg  [22:0] sync2;
    reg         wr_prev;
    wire [4:0]  s_addr  = sync2[4:0];
    wire [15:0] s_wdata = sync2[20:5];
    wire        s_wr    = sync2[21];
    wire        s_rd    = sync2[22];
    reg  [1:0]  sense1;
    reg  [1:0]  sense2;

    wire        ram_we    = (state == S_RAM) && !ram_chk;
    wire [15:0] ram_wdata = ram_phase[1] ? `HASP_SRAM_ZERO : `HASP_SRAM_ONES;
    wire [15:0] ram_rdata;
    wire [15:0] crc_value;
    wire        ram_last  = (ram_addr == 8'hff);
    wire        prog_wrap = (prog_addr == 8'h00);
    wire        ready     = (state == S_RUN);
    wire        wr_event  = s_wr && !wr_prev;
    wire        att_write = wr_event && (s_addr == `HASP_OFS_ATTENTION);
    wire        accept    = att_write && ready;
    wire [1:0]  att_type  = s_wdata[1:0];

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    hasp_sram u_sram
    (
        .mclk  (mclk),
        .we    (ram_we),
        .addr  (ram_addr),
        .wdata (ram_wdata),
        .rdata (ram_rdata)
    );

    hasp_crc u_crc
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .clear (state == S_INIT),
        .en    ((state == S_CRC) && crc_chk),
        .data  (prog_data),
        .crc   (crc_value)
    );

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Two flops on every host and sense pin before use
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sync1   <= 23'h0;
            sync2   <= 23'h0;
            wr_prev <= 1'b0;
            sense1  <= 2'h0;
            sense2  <= 2'h0;
        end
        else
        begin
            sync1   <= {~host_rd_n, ~host_wr_n, host_wdata, host_addr};
            sync2   <= sync1;
            wr_prev <= s_wr;
            sense1  <= {term_power, fuse_ok};
            sense2  <= sense1;
        end
    end

    // ----------------------------------------------------------------
    // Self-test sequencer
    // ----------------------------------------------------------------
    // Walks the tests, holds the running code, decides pass or fail
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state           <= S_INIT;
            test_code       <= `HASP_ST_RESET_VAL;
            timer           <= 32'h0;
            ram_phase       <= 2'h0;
            ram_chk         <= 1'b0;
            ram_addr        <= 8'h0;
            crc_chk         <= 1'b0;
            prog_addr       <= 8'h0;
            cpu_step        <= 3'h0;
            cpu_acc         <= 8'h0;
            cpu_store       <= 8'h0;
            selftest_failed <= 1'b0;
        end
        else
        begin
            if (timer != SELFTEST_CYCLES)
                timer <= timer + 32'h1;
            case (state)
                S_INIT:
                begin
                    state     <= S_RAM;
                    test_code <= `HASP_TC_SRAM;
                end
                S_RAM:
                begin
                    // Fill ones, check, fill zeros, check
                    if (!ram_chk)
                    begin
                        ram_addr <= ram_addr + 8'h1;
                        if (ram_last)
                            ram_chk <= 1'b1;
                    end
                    else if (!ram_phase[0])
                        ram_phase[0] <= 1'b1;
                    else if (ram_rdata != ram_wdata)
                        state <= S_FAIL;
                    else
                    begin
                        ram_phase[0] <= 1'b0;
                        ram_addr     <= ram_addr + 8'h1;
                        if (ram_last && ram_phase[1])
                        begin
                            state     <= S_CRC;
                            test_code <= `HASP_TC_CRC;
                        end
                        else if (ram_last)
                        begin
                            ram_phase[1] <= 1'b1;
                            ram_chk      <= 1'b0;
                        end
                    end
                end
                S_CRC:
                begin
                    // Address leads data by one edge; last word lands after the wrap
                    crc_chk   <= 1'b1;
                    prog_addr <= prog_addr + 8'h1;
                    if (crc_chk && prog_wrap)
                    begin
                        crc_chk <= 1'b0;
                        state   <= S_CPU;
                    end
                end
                S_CPU:
                begin
                    if (cpu_step == 3'h0 && crc_value != stored_crc)
                        state <= S_FAIL;
                    else
                    begin
                        cpu_step <= cpu_step + 3'h1;
                        case (cpu_step)
                            3'h0:
                            begin
                                test_code <= `HASP_TC_ACC;
                                cpu_acc   <= 8'h5a + 8'ha5;
                            end
                            3'h1:
                            begin
                                test_code <= `HASP_TC_STORE;
                                cpu_store <= cpu_acc;
                                if (cpu_acc != 8'hff)
                                    state <= S_FAIL;
                            end
                            3'h2:
                            begin
                                test_code <= `HASP_TC_SHIFT;
                                cpu_acc   <= {cpu_acc[6:0], 1'b0};
                                if (cpu_store != 8'hff)
                                    state <= S_FAIL;
                            end
                            3'h3:
                            begin
                                test_code <= `HASP_TC_CMP;
                                if (cpu_acc != 8'hfe)
                                    state <= S_FAIL;
                            end
                            3'h4:
                            begin
                                test_code <= `HASP_TC_JUMP;
                                if (!(cpu_acc < cpu_store))
                                    state <= S_FAIL;
                            end
                            default:
                            begin
                                if (cpu_step != 3'h5)
                                    state <= S_FAIL;
                                else
                                    state <= S_TERM;
                            end
                        endcase
                    end
                end
                S_TERM:
                begin
                    // Fuse blown: report whether power still reaches the connector
                    if (!sense2[0])
                    begin
                        test_code <= sense2[1] ? `HASP_TC_TERM_PRESENT
                                               : `HASP_TC_TERM_ABSENT;
                        state     <= S_FAIL;
                    end
                    else
                        state <= S_WAIT;
                end
                S_WAIT:
                begin
                    if (timer == SELFTEST_CYCLES)
                        state <= S_RUN;
                end
                S_RUN:
                    state <= S_RUN;
                S_FAIL:
                    selftest_failed <= 1'b1;
                default:
                    state <= S_FAIL;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Attention decode and list runner
    // ----------------------------------------------------------------
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            entered          <= 1'b0;
            err              <= 1'b0;
            err_code         <= 8'h0;
            single_cmd_start <= 1'b0;
            target_ack       <= 1'b0;
            list_run         <= 1'b0;
            list_busy        <= 1'b0;
            list_out_index   <= 8'h0;
            list_block_start <= 1'b0;
            list_block_index <= 8'h0;
        end
        else
        begin
            single_cmd_start <= accept && att_type == `HASP_ATT_SINGLE;
            target_ack       <= accept && att_type == `HASP_ATT_TARGET_ACK;
            list_block_start <= 1'b0;
            if (accept && att_type == `HASP_ATT_SINGLE)
                entered <= !entered;
            if (accept && att_type == `HASP_ATT_LIST && !list_active)
            begin
                err      <= 1'b1;
                err_code <= `HASP_ERR_LIST_STATE;
            end
            // Block issue until outbound reaches inbound
            if (list_busy)
            begin
                if (list_block_done)
                begin
                    list_busy      <= 1'b0;
                    list_out_index <= list_out_index + 8'h1;
                end
            end
            else if (list_run && list_out_index != list_inbound_index)
            begin
                list_busy        <= 1'b1;
                list_block_start <= 1'b1;
                list_block_index <= list_out_index;
            end
            else if (list_run)
                list_run <= 1'b0;
            // New attention wins over the run clearing
            if (accept && att_type == `HASP_ATT_LIST && list_active)
                list_run <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Status read
    // ----------------------------------------------------------------
    // Reset layout until ready, general layout after
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            host_rdata    <= 16'h0;
            host_rdata_oe <= 1'b0;
        end
        else
        begin
            host_rdata_oe <= s_rd && (s_addr == `HASP_OFS_STATUS);
            if (!ready)
                host_rdata <= {8'h00, test_code[7:2], 1'b0, test_code[0]};
            else
                host_rdata <= {err ? err_code : `HASP_BOARD_TYPE, 3'h0, err,
                               2'h0, 1'b1, entered};
        end
    end

endmodule // hasp_top

// ---- testbench/hasp_far_model.sv ----
// Far side: program memory with stored CRC, and a command engine
// that ends each list block after a set delay.
module hasp_far_model
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Bench controls
    input  wire logic        crc_bad,
    input  wire logic [3:0]  done_delay,
    // Program memory
    input  wire logic [7:0]  prog_addr,
    output logic      [15:0] prog_data,
    output logic      [15:0] stored_crc,
    // Command engine
    input  wire logic        list_block_start,
    output logic             list_block_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] rom [0:255];
    logic [15:0] crc_good;
    logic [3:0]  wait_cnt;
    // Fill memory and work out its CRC, msb first
    initial
    begin
        crc_good = 16'hffff;
        for (int i = 0; i < 256; i++)
        begin
            rom[i] = (16'h1357 * 16'(i)) ^ 16'ha5c3;
            for (int b = 15; b >= 0; b--)
                crc_good = {crc_good[14:0], 1'b0} ^ ((crc_good[15] ^ rom[i][b]) ? 16'h1021 : 16'h0);
        end
    end
    // A bad stored value makes the firmware check fail
    assign stored_crc = crc_bad ? ~crc_good : crc_good;
    // Word one edge after its address
    always @(posedge mclk)
        prog_data <= rom[prog_addr];
    // Block finishes done_delay plus one cycles after its start
    always @(posedge mclk)
    begin
        list_block_done <= 1'b0;
        if (!rst_n)
            wait_cnt <= 4'h0;
        else if (list_block_start)
            wait_cnt <= done_delay;
        else if (wait_cnt != 4'h0)
        begin
            wait_cnt <= wait_cnt - 4'h1;
            list_block_done <= (wait_cnt == 4'h1);
        end
    end
endmodule // hasp_far_model

// ---- testbench/hasp_top_sva.sv ----
// Checker on the status read pins and the command engine pulses of hasp_top.
// Assumes one clock, mclk, and synchronous active-low rst_n.
module hasp_top_sva
#(
    parameter [31:0] SELFTEST_CYCLES = 32'd50000000
)
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Status and design pulses
    input  wire logic [15:0] host_rdata,
    input  wire logic        single_cmd_start,
    input  wire logic        list_block_start,
    input  wire logic [7:0]  list_block_index,
    input  wire logic        target_ack,
    input  wire logic        selftest_failed
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [31:0] since;
    logic        ent_before;
    // Cycles since release; entered bit at each single start
    always @(posedge mclk)
    begin
        if (!rst_n)
            since <= 32'h0;
        else
            since <= since + 32'h1;
        if (single_cmd_start)
            ent_before <= host_rdata[0];
    end
    a_reset_value: assert property ($rose(rst_n) |-> ##[0:2] (host_rdata == 16'h00fd))
        else $error("status not fd after reset");
    a_ready_early: assert property (host_rdata[1] |-> since + 32'd4 >= SELFTEST_CYCLES)
        else $error("ready before self-test time");
    a_ready_late: assert property ((since >= SELFTEST_CYCLES + 32'd8) && !selftest_failed
        |-> host_rdata[1])
        else $error("ready missing after pass");
    a_test_fields_zero: assert property (!host_rdata[1] |-> host_rdata[15:8] == 8'h00)
        else $error("reset layout upper byte not zero");
    a_ready_holds: assert property (host_rdata[1] |=> host_rdata[1])
        else $error("ready dropped");
    a_fail_refuses: assert property ((single_cmd_start || target_ack)
        |-> !selftest_failed && $past(host_rdata[1]))
        else $error("command while not ready");
    a_failed_not_ready: assert property (selftest_failed |-> !host_rdata[1])
        else $error("ready set after failure");
    a_ent_toggles: assert property (single_cmd_start |-> ##[1:2] (host_rdata[0] != ent_before))
        else $error("entered bit did not toggle");
    a_err_code: assert property (host_rdata[1] && host_rdata[4] |-> host_rdata[15:8] == 8'h11)
        else $error("error code not 11");
    a_board_type: assert property (host_rdata[1] && !host_rdata[4]
        |-> host_rdata[15:8] == 8'h02)
        else $error("board type missing");
    a_pulse_short: assert property (single_cmd_start |=> !single_cmd_start)
        else $error("single start too long");
    a_block_index: assert property ($changed(list_block_index) |-> list_block_start)
        else $error("index moved without start");
endmodule // hasp_top_sva

bind hasp_top hasp_top_sva #(.SELFTEST_CYCLES(SELFTEST_CYCLES)) u_sva
(
    .mclk(mclk), .rst_n(rst_n), .host_rdata(host_rdata), .single_cmd_start(single_cmd_start),
    .list_block_start(list_block_start), .list_block_index(list_block_index),
    .target_ack(target_ack), .selftest_failed(selftest_failed)
);

// ---- testbench/tb.sv ----
// Bench for hasp_top: host writes and status reads.
// Assumes the far model supplies program memory and block completion.
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int ST = 3000;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  host_addr = 5'h08;
    logic        host_wr_n = 1'b1;
    logic        host_rd_n = 1'b1;
    logic [15:0] host_wdata = 16'h0000;
    logic        fuse_ok = 1'b1;
    logic        term_power = 1'b1;
    logic        crc_bad = 1'b0;
    logic [3:0]  done_delay = 4'h1;
    logic        list_active = 1'b0;
    logic [7:0]  list_inbound_index = 8'h00;
    logic [15:0] host_rdata, prog_data, stored_crc;
    logic [7:0]  prog_addr, list_block_index;
    logic        host_rdata_oe, list_block_done, single_cmd_start;
    logic        list_block_start, target_ack, selftest_failed;
    int          num_errors = 0, checks = 0, n_single = 0, n_target = 0, n_blocks = 0;
    int          s0, g0, b0;
    logic [15:0] t_data [5] = '{16'h0000, 16'h0004, 16'h0002, 16'h0003, 16'h0000};
    logic [15:0] t_stat [5] = '{16'h0203, 16'h0202, 16'h0202, 16'h0202, 16'h0202};
    logic [15:0] f_stat [3] = '{16'h000c, 16'h00a8, 16'h00ac};

    always #50 mclk = ~mclk;
    // Count design pulses
    always @(posedge mclk)
    begin
        n_single <= n_single + int'(single_cmd_start === 1'b1);
        n_target <= n_target + int'(target_ack === 1'b1);
        n_blocks <= n_blocks + int'(list_block_start === 1'b1);
    end

    hasp_top #(.SELFTEST_CYCLES(ST)) dut
    (
        .mclk(mclk), .rst_n(rst_n), .host_addr(host_addr), .host_wr_n(host_wr_n),
        .host_rd_n(host_rd_n), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_rdata_oe(host_rdata_oe), .fuse_ok(fuse_ok), .term_power(term_power),
        .prog_addr(prog_addr), .prog_data(prog_data), .stored_crc(stored_crc),
        .list_active(list_active), .list_inbound_index(list_inbound_index),
        .list_block_done(list_block_done), .single_cmd_start(single_cmd_start),
        .list_block_start(list_block_start), .list_block_index(list_block_index),
        .target_ack(target_ack), .selftest_failed(selftest_failed)
    );
    hasp_far_model far
    (
        .mclk(mclk), .rst_n(rst_n), .crc_bad(crc_bad), .done_delay(done_delay),
        .prog_addr(prog_addr), .prog_data(prog_data), .stored_crc(stored_crc),
        .list_block_start(list_block_start), .list_block_done(list_block_done)
    );

    // --------
    // Host access, reset, block wait and end tasks
    // --------
    task automatic end_sim;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic host_write(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        host_addr <= a;
        host_wdata <= d;
        host_wr_n <= 1'b0;
        repeat (4) @(posedge mclk);
        host_wr_n <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask

    task automatic check_status(input string nm, input logic [15:0] exp);
        @(posedge mclk);
        host_addr <= 5'h10;
        host_rd_n <= 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        `CHK("read_enable", 1'b1, host_rdata_oe)
        `CHK(nm, exp, host_rdata)
        host_rd_n <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask

    task automatic do_reset(input logic c, input logic f, input logic t);
        @(posedge mclk);
        rst_n <= 1'b0;
        crc_bad <= c;
        fuse_ok <= f;
        term_power <= t;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
    endtask

    task automatic wait_blocks(input int want);
        for (int n = 0; n_blocks - b0 < want; n++)
        begin
            @(posedge mclk);
            if (n > 300)
            begin
                num_errors++;
                $display("ERROR block_wait expected %0d seen %0d", want, n_blocks - b0);
                end_sim();
            end
        end
        repeat (20) @(posedge mclk);
    endtask

    // --------
    // Main sequence
    // --------
    initial
    begin
        int n;
        logic fd_seen;
        do_reset(1'b0, 1'b1, 1'b1);
        fd_seen = 1'b0;
        repeat (3)
        begin
            @(posedge mclk);
            #1;
            fd_seen = fd_seen | (host_rdata === 16'h00fd);
        end
        `CHK("reset_value", 1'b1, fd_seen)
        s0 = n_single;
        host_write(5'h08, 16'h0000);
        `CHK("early_single", s0, n_single)
        for (n = 0; host_rdata[1] !== 1'b1; n++)
        begin
            @(posedge mclk);
            if (n > ST + 200)
            begin
                num_errors++;
                $display("ERROR ready_wait expected 1 seen 0");
                end_sim();
            end
        end
        `CHK("ready_time", 1'b1, n >= ST - 40)
        check_status("general_status", 16'h0202);
        for (int i = 0; i < 5; i++)
        begin
            s0 = n_single;
            g0 = n_target;
            host_write(i == 4 ? 5'h00 : 5'h08, t_data[i]);
            `CHK("single_count", int'(i < 2), n_single - s0)
            `CHK("target_count", int'(i == 2), n_target - g0)
            check_status("attention_status", t_stat[i]);
        end
        b0 = n_blocks;
        list_inbound_index <= 8'h03;
        list_active <= 1'b1;
        done_delay <= 4'h5;
        host_write(5'h08, 16'h0001);
        wait_blocks(3);
        `CHK("block_count", 3, n_blocks - b0)
        `CHK("block_index", 8'h02, list_block_index)
        list_inbound_index <= 8'h04;
        done_delay <= 4'h1;
        host_write(5'h08, 16'h0001);
        wait_blocks(4);
        `CHK("block_index", 8'h03, list_block_index)
        check_status("list_status", 16'h0202);
        list_active <= 1'b0;
        b0 = n_blocks;
        host_write(5'h08, 16'h0001);
        `CHK("block_count", 0, n_blocks - b0)
        check_status("list_error", 16'h1112);
        for (int i = 0; i < 3; i++)
        begin
            do_reset(i == 0, i == 0, i == 1);
            repeat (ST + 300) @(posedge mclk);
            check_status("fail_code", f_stat[i]);
            `CHK("fail_flag", 1'b1, selftest_failed)
            s0 = n_single;
            host_write(5'h08, 16'h0000);
            `CHK("refused_single", s0, n_single)
        end
        end_sim();
    end
endmodule // tb
